// File: hw/amic_defs.svh
`ifndef AMIC_DEFS_SVH
`define AMIC_DEFS_SVH

// Register addresses on the serial register port
`define AMIC_ADDR_W 6
`define AMIC_ADDR_OPCTRL 6'h01
`define AMIC_ADDR_IFOPT 6'h02

// Reset values
`define AMIC_RST_OPCTRL 16'h2000
`define AMIC_RST_IFOPT 16'h0000

// Writable bits; everything else is reserved and reads as zero
`define AMIC_MASK_OPCTRL 16'hE77C
`define AMIC_MASK_IFOPT 16'h19EC

// Operating control fields
`define AMIC_OPC_REFEN 15
`define AMIC_OPC_SINGCYC 13
`define AMIC_OPC_DELAY_MSB 10
`define AMIC_OPC_DELAY_LSB 8
`define AMIC_OPC_MODE_MSB 6
`define AMIC_OPC_MODE_LSB 4
`define AMIC_OPC_CLK_MSB 3
`define AMIC_OPC_CLK_LSB 2

// Interface option fields
`define AMIC_IFO_ALTSYNC 12
`define AMIC_IFO_DRIVE 11
`define AMIC_IFO_DOUTRST 8
`define AMIC_IFO_CONTINUOUS_RESULT_READ 7
`define AMIC_IFO_STATAPP 6
`define AMIC_IFO_REGCHK 5
`define AMIC_IFO_CRC_MSB 3
`define AMIC_IFO_CRC_LSB 2

`endif

// File: hw/amic_pkg.sv
package amic_pkg;

	typedef enum logic [2:0]
	{
		AMIC_MODE_CONT = 3'h0,
		AMIC_MODE_SINGLE = 3'h1,
		AMIC_MODE_STANDBY = 3'h2,
		AMIC_MODE_PWRDN = 3'h3,
		AMIC_MODE_INT_OFS = 3'h4,
		AMIC_MODE_INT_GAIN = 3'h5,
		AMIC_MODE_SYS_OFS = 3'h6,
		AMIC_MODE_SYS_GAIN = 3'h7
	} amic_opmode_type;

	typedef enum logic [1:0]
	{
		AMIC_CLK_INT = 2'h0,
		AMIC_CLK_INT_OUT = 2'h1,
		AMIC_CLK_EXT = 2'h2,
		AMIC_CLK_XTAL = 2'h3
	} amic_clksrc_type;

	// Gray along idle -> start -> run -> end
	typedef enum logic [1:0]
	{
		AMIC_SEQ_IDLE = 2'b00,
		AMIC_SEQ_START = 2'b01,
		AMIC_SEQ_RUN = 2'b11,
		AMIC_SEQ_END = 2'b10
	} amic_seq_state_type;

endpackage

// File: hw/amic_mode_seq.sv
`timescale 1ns/1ps
`default_nettype none

module amic_mode_seq
	import amic_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic modeWrite,
	input wire logic [2:0] modeNew,
	input wire logic convDone,
	input wire logic calDone,
	output logic filterReset,
	output logic startConv,
	output logic backToStandby,
	output logic seqBusy
);

	amic_seq_state_type state_r;
	amic_seq_state_type state_nxt;
	amic_opmode_type mode_r;
	logic oneShot;
	logic isCal;
	logic runs;

	assign oneShot = (mode_r == AMIC_MODE_SINGLE);
	assign isCal = mode_r[2];
	assign runs = (mode_r == AMIC_MODE_CONT) || oneShot || isCal;

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			mode_r <= AMIC_MODE_STANDBY;
		else if (modeWrite)
			mode_r <= amic_opmode_type'(modeNew);
	end

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			AMIC_SEQ_IDLE:
				state_nxt = AMIC_SEQ_IDLE;
			AMIC_SEQ_START:
				state_nxt = runs ? AMIC_SEQ_RUN : AMIC_SEQ_IDLE;
			AMIC_SEQ_RUN:
				if ((oneShot && convDone) || (isCal && calDone))
					state_nxt = AMIC_SEQ_END;
			AMIC_SEQ_END:
				state_nxt = AMIC_SEQ_IDLE;
		endcase
		// A fresh write always restarts, even mid conversion
		if (modeWrite)
			state_nxt = AMIC_SEQ_START;
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			state_r <= AMIC_SEQ_IDLE;
		else
			state_r <= state_nxt;
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			filterReset <= 1'b0;
			startConv <= 1'b0;
			backToStandby <= 1'b0;
			seqBusy <= 1'b0;
		end
		else
		begin
			filterReset <= modeWrite;
			startConv <= (state_nxt == AMIC_SEQ_RUN) && (state_r == AMIC_SEQ_START);
			backToStandby <= (state_nxt == AMIC_SEQ_END) && !modeWrite;
			seqBusy <= (state_nxt == AMIC_SEQ_RUN);
		end
	end

endmodule

`default_nettype wire

// File: hw/amic_config.sv
// Functional notes
// - Mode field bits 6:4 picks continuous, single, standby, power-down or one of four calibrations.
// - Clock field bits 3:2 picks internal, internal driven out, external in, or crystal.
// - Internal oscillator selection also powers and enables that oscillator.
// - Mode register bits 1:0 are reserved; writes ignored, reads give zero.
// - Interface option register at address 0x02, resets to 0x0000.
// - Bit 12 gives sync its alternate role, gating conversions while cycling channels.
// - Bit 11 raises drive strength of the data-out/ready pin.
// - Bit 7 enables continuous read of the conversion result, in continuous conversion mode only.
// - Bit 6 appends the status register after every result read.
// - Any mode register write resets filter and ready, then starts per written mode.
// - Mode register is 16 bits at address 0x01, reset value 0x2000.
`timescale 1ns/1ps
`default_nettype none
`include "amic_defs.svh"

module amic_config
	import amic_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [5:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [15:0] regRdData,
	output logic regRdValid,
	input wire logic convDone,
	input wire logic calDone,
	input wire logic syncIn,
	input wire logic multiChannel,
	output logic [2:0] modeSel,
	output logic filterReset,
	output logic readyReset,
	output logic startConv,
	output logic convBusy,
	output logic powerDown,
	output logic oscEnable,
	output logic clkIoOutEn,
	output logic extClkSel,
	output logic crystalEn,
	output logic refEnable,
	output logic singleCycle,
	output logic [2:0] settleDelay,
	output logic altSyncEn,
	output logic convHold,
	output logic syncFilterReset,
	output logic driveBoost,
	output logic doutResetEn,
	output logic contReadActive,
	output logic statusAppend,
	output logic regCheckEn,
	output logic [1:0] crcMode
);

	logic [15:0] opCtrl_r;
	logic [15:0] ifOpt_r;
	logic opWrite;
	logic ifWrite;
	logic seqFilterReset;
	logic seqStart;
	logic seqStandby;
	logic seqBusy;
	logic [2:0] modeNow;
	logic [1:0] clkNow;

	////////////////////////////////////////////////////////////////
	// Address decode
	assign opWrite = regWrEn && (regAddr == `AMIC_ADDR_OPCTRL);
	assign ifWrite = regWrEn && (regAddr == `AMIC_ADDR_IFOPT);

	////////////////////////////////////////////////////////////////
	// Operating control register
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			opCtrl_r <= `AMIC_RST_OPCTRL;
		else if (opWrite)
			opCtrl_r <= regWrData & `AMIC_MASK_OPCTRL;
		else if (seqStandby)
			// Host write takes priority over the automatic return
			opCtrl_r[`AMIC_OPC_MODE_MSB:`AMIC_OPC_MODE_LSB] <= AMIC_MODE_STANDBY;
	end

	assign modeNow = opCtrl_r[`AMIC_OPC_MODE_MSB:`AMIC_OPC_MODE_LSB];
	assign clkNow = opCtrl_r[`AMIC_OPC_CLK_MSB:`AMIC_OPC_CLK_LSB];

	////////////////////////////////////////////////////////////////
	// Interface option register
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			ifOpt_r <= `AMIC_RST_IFOPT;
		else if (ifWrite)
			ifOpt_r <= regWrData & `AMIC_MASK_IFOPT;
	end

	////////////////////////////////////////////////////////////////
	// Register read port; unmapped addresses return zero
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			regRdData <= 16'h0000;
			regRdValid <= 1'b0;
		end
		else
		begin
			regRdValid <= regRdEn;
			if (regRdEn)
			begin
				unique case (regAddr)
					`AMIC_ADDR_OPCTRL:
						regRdData <= opCtrl_r & `AMIC_MASK_OPCTRL;
					`AMIC_ADDR_IFOPT:
						regRdData <= ifOpt_r;
					default:
						regRdData <= 16'h0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Conversion sequencing
	amic_mode_seq u_seq
	(
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.modeWrite(opWrite),
		.modeNew(regWrData[`AMIC_OPC_MODE_MSB:`AMIC_OPC_MODE_LSB]),
		.convDone(convDone),
		.calDone(calDone),
		.filterReset(seqFilterReset),
		.startConv(seqStart),
		.backToStandby(seqStandby),
		.seqBusy(seqBusy)
	);

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			filterReset <= 1'b0;
			readyReset <= 1'b0;
			startConv <= 1'b0;
			convBusy <= 1'b0;
		end
		else
		begin
			filterReset <= seqFilterReset;
			readyReset <= seqFilterReset;
			startConv <= seqStart;
			convBusy <= seqBusy;
		end
	end

	////////////////////////////////////////////////////////////////
	// Mode and clock source outputs
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			modeSel <= 3'h0;
			powerDown <= 1'b0;
		end
		else
		begin
			modeSel <= modeNow;
			powerDown <= (modeNow == AMIC_MODE_PWRDN);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			oscEnable <= 1'b1;
			clkIoOutEn <= 1'b0;
			extClkSel <= 1'b0;
			crystalEn <= 1'b0;
		end
		else
		begin
			// Oscillator also runs when it is driven out on the clock pin
			oscEnable <= (clkNow == AMIC_CLK_INT) || (clkNow == AMIC_CLK_INT_OUT);
			clkIoOutEn <= (clkNow == AMIC_CLK_INT_OUT);
			extClkSel <= (clkNow == AMIC_CLK_EXT);
			crystalEn <= (clkNow == AMIC_CLK_XTAL);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			refEnable <= 1'b0;
			singleCycle <= 1'b1;
			settleDelay <= 3'h0;
		end
		else
		begin
			refEnable <= opCtrl_r[`AMIC_OPC_REFEN];
			singleCycle <= opCtrl_r[`AMIC_OPC_SINGCYC];
			settleDelay <= opCtrl_r[`AMIC_OPC_DELAY_MSB:`AMIC_OPC_DELAY_LSB];
		end
	end

	////////////////////////////////////////////////////////////////
	// Sync pin handling
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			altSyncEn <= 1'b0;
			convHold <= 1'b0;
			syncFilterReset <= 1'b0;
		end
		else
		begin
			altSyncEn <= ifOpt_r[`AMIC_IFO_ALTSYNC];
			if (ifOpt_r[`AMIC_IFO_ALTSYNC])
			begin
				// Alternate role only gates the channel cycling, filter kept
				convHold <= multiChannel && !syncIn;
				syncFilterReset <= 1'b0;
			end
			else
			begin
				convHold <= !syncIn;
				syncFilterReset <= !syncIn;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Serial interface options
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			driveBoost <= 1'b0;
			doutResetEn <= 1'b0;
			contReadActive <= 1'b0;
			statusAppend <= 1'b0;
			regCheckEn <= 1'b0;
			crcMode <= 2'h0;
		end
		else
		begin
			driveBoost <= ifOpt_r[`AMIC_IFO_DRIVE];
			doutResetEn <= ifOpt_r[`AMIC_IFO_DOUTRST];
			// Not meaningful outside continuous conversion, so held off there
			contReadActive <= ifOpt_r[`AMIC_IFO_CONTINUOUS_RESULT_READ] && (modeNow == AMIC_MODE_CONT);
			statusAppend <= ifOpt_r[`AMIC_IFO_STATAPP];
			regCheckEn <= ifOpt_r[`AMIC_IFO_REGCHK];
			crcMode <= ifOpt_r[`AMIC_IFO_CRC_MSB:`AMIC_IFO_CRC_LSB];
		end
	end

endmodule

`default_nettype wire

// File: test/amic_config_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "amic_defs.svh"

module amic_config_chk
	import amic_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [5:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [15:0] regRdData,
	input wire logic regRdValid,
	input wire logic convDone,
	input wire logic [2:0] modeSel,
	input wire logic filterReset,
	input wire logic readyReset,
	input wire logic startConv,
	input wire logic oscEnable,
	input wire logic clkIoOutEn,
	input wire logic extClkSel,
	input wire logic crystalEn,
	input wire logic altSyncEn,
	input wire logic driveBoost,
	input wire logic statusAppend,
	input wire logic contReadActive
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	sequence sModeWr;
		regWrEn && regAddr == `AMIC_ADDR_OPCTRL;
	endsequence
	sequence sIfWr;
		regWrEn && regAddr == `AMIC_ADDR_IFOPT;
	endsequence
	// Only modes that run; a second write right after would cancel the start
	sequence sRunStart;
		regWrEn && regAddr == `AMIC_ADDR_OPCTRL && regWrData[6:4] != 3'h2 && regWrData[6:4] != 3'h3 ##1 !regWrEn;
	endsequence
	////////////////////////////////////////
	a_mode_follows: assert property
		(sModeWr |-> ##2 modeSel == $past(regWrData[6:4], 2)) else $error("mode field not applied");
	a_clock_select: assert property
		(sModeWr |-> ##2 {clkIoOutEn, extClkSel, crystalEn} == {$past(regWrData[3:2], 2) == 2'h1,
		$past(regWrData[3:2], 2) == 2'h2, $past(regWrData[3:2], 2) == 2'h3}) else $error("clock select wrong");
	a_osc_enable: assert property
		(sModeWr |-> ##2 oscEnable == !$past(regWrData[3], 2)) else $error("oscillator enable wrong");
	a_filter_reset: assert property
		(sModeWr |-> ##2 filterReset && readyReset) else $error("no filter reset on mode write");
	a_start_pulse: assert property
		(sRunStart |-> ##2 startConv) else $error("no start after run mode write");
	a_reserved_zero: assert property
		(regRdValid && $past(regAddr) == `AMIC_ADDR_OPCTRL |-> regRdData[1:0] == 2'h0) else $error("reserved bits set");
	a_read_answer: assert property
		(regRdValid == $past(regRdEn)) else $error("read valid timing");
	a_unmapped_zero: assert property
		(regRdValid && !($past(regAddr) inside {6'h01, 6'h02}) |-> regRdData == 16'h0000) else $error("unmapped read");
	a_iface_bits: assert property
		(sIfWr |-> ##2 {altSyncEn, driveBoost, statusAppend} == {$past(regWrData[12:11], 2), $past(regWrData[6], 2)})
		else $error("interface option wrong");
	a_continuous_result_read_gate: assert property
		(contReadActive |-> modeSel == AMIC_MODE_CONT) else $error("continuous read outside continuous mode");
	a_standby_return: assert property
		(convDone && modeSel == AMIC_MODE_SINGLE |-> ##3 modeSel == AMIC_MODE_STANDBY) else $error("no standby return");
endmodule

bind amic_config amic_config_chk u_chk
(
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.regAddr(regAddr),
	.regWrData(regWrData),
	.regWrEn(regWrEn),
	.regRdEn(regRdEn),
	.regRdData(regRdData),
	.regRdValid(regRdValid),
	.convDone(convDone),
	.modeSel(modeSel),
	.filterReset(filterReset),
	.readyReset(readyReset),
	.startConv(startConv),
	.oscEnable(oscEnable),
	.clkIoOutEn(clkIoOutEn),
	.extClkSel(extClkSel),
	.crystalEn(crystalEn),
	.altSyncEn(altSyncEn),
	.driveBoost(driveBoost),
	.statusAppend(statusAppend),
	.contReadActive(contReadActive)
);

`default_nettype wire

// File: test/amic_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module amic_core_model
#(
	parameter int DELAY = 20
)
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic startConv,
	input wire logic convBusy,
	input wire logic [2:0] modeSel,
	output logic convDone = 1'b0,
	output logic calDone = 1'b0
);
	// Fixed conversion time; a real core varies it with filter settings
	int cnt = 0;
	always @(negedge clk_sys)
	begin
		convDone <= 1'b0;
		calDone <= 1'b0;
		if (sys_rst || !convBusy || startConv)
			cnt <= 0;
		else if (cnt == DELAY)
		begin
			cnt <= 0;
			calDone <= modeSel[2];
			convDone <= !modeSel[2];
		end
		else
			cnt <= cnt + 1;
	end
endmodule

`default_nettype wire

// File: test/amic_config_tb.sv
`timescale 1ns/1ps
`default_nettype none

module amic_config_tb;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [5:0] regAddr = 6'h00;
	logic [15:0] regWrData = 16'h0000;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic syncIn = 1'b1;
	logic multiChannel = 1'b0;
	logic [15:0] regRdData;
	logic regRdValid, convDone, calDone, startConv, convBusy, powerDown, oscEnable, clkIoOutEn;
	logic extClkSel, crystalEn, altSyncEn, convHold, driveBoost, contReadActive, statusAppend;
	logic filterReset, readyReset, refEnable, singleCycle, syncFilterReset, doutResetEn, regCheckEn;
	logic [2:0] settleDelay;
	logic [1:0] crcMode;
	logic [2:0] modeSel;
	logic [2:0] mode;
	int num_errors = 0;
	int n_compared = 0;
	int cyc = 0;

	amic_config DUT
	(
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWrEn(regWrEn),
		.regRdEn(regRdEn),
		.regRdData(regRdData),
		.regRdValid(regRdValid),
		.convDone(convDone),
		.calDone(calDone),
		.syncIn(syncIn),
		.multiChannel(multiChannel),
		.modeSel(modeSel),
		.filterReset(filterReset),
		.readyReset(readyReset),
		.startConv(startConv),
		.convBusy(convBusy),
		.powerDown(powerDown),
		.oscEnable(oscEnable),
		.clkIoOutEn(clkIoOutEn),
		.extClkSel(extClkSel),
		.crystalEn(crystalEn),
		.refEnable(refEnable),
		.singleCycle(singleCycle),
		.settleDelay(settleDelay),
		.altSyncEn(altSyncEn),
		.convHold(convHold),
		.syncFilterReset(syncFilterReset),
		.driveBoost(driveBoost),
		.doutResetEn(doutResetEn),
		.contReadActive(contReadActive),
		.statusAppend(statusAppend),
		.regCheckEn(regCheckEn),
		.crcMode(crcMode)
	);
	amic_core_model u_core
	(
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.startConv(startConv),
		.convBusy(convBusy),
		.modeSel(modeSel),
		.convDone(convDone),
		.calDone(calDone)
	);

	always #20 clk_sys = ~clk_sys;
	////////////////////////////////////////
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [16:0] s, input logic [16:0] e);
		n_compared++;
		if (s !== e)
		begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(negedge clk_sys);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge clk_sys);
		regWrEn = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask

	task automatic rd(input logic [5:0] a, input logic [15:0] e);
		@(negedge clk_sys);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge clk_sys);
		regRdEn = 1'b0;
		check({regRdValid, regRdData}, {1'b1, e});
	endtask

	// Bounded so a stuck sequencer shows up as a read mismatch, not a hang
	task automatic waitIdle;
		for (int i = 0; i < 200 && convBusy !== 1'b0; i++)
			@(negedge clk_sys);
	endtask
	////////////////////////////////////////
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			summarize();
		end
	end

	initial
	begin
		repeat (4) @(negedge clk_sys);
		sys_rst = 1'b0;
		rd(6'h01, 16'h2000);
		rd(6'h02, 16'h0000);
		check(17'(oscEnable), 17'h1);
		check(17'({refEnable, singleCycle, settleDelay}), 17'h08);
		wr(6'h01, 16'h0023);
		rd(6'h01, 16'h0020);
		wr(6'h03, 16'hFFFF);
		rd(6'h03, 16'h0000);
		for (int c = 0; c < 4; c++)
		begin
			wr(6'h01, 16'h0020 | 16'(c << 2));
			check(17'({oscEnable, clkIoOutEn, extClkSel, crystalEn}), 17'({c < 2, c == 1, c == 2, c == 3}));
		end
		// Continuous last, so a late result never lands on a fresh single conversion
		for (int m = 1; m < 9; m++)
		begin
			mode = 3'(m);
			wr(6'h01, {9'h000, mode, 4'h0});
			check(17'({powerDown, modeSel}), 17'({mode == 3'h3, mode}));
			waitIdle();
			check(17'(convBusy), 17'(mode == 3'h0));
			rd(6'h01, (mode == 3'h1 || mode[2]) ? 16'h0020 : {9'h000, mode, 4'h0});
		end
		wr(6'h02, 16'hFFFF);
		rd(6'h02, 16'h19EC);
		check(17'({doutResetEn, regCheckEn, crcMode}), 17'hF);
		check(17'({altSyncEn, driveBoost, statusAppend, contReadActive}), 17'hF);
		syncIn = 1'b0;
		multiChannel = 1'b1;
		repeat (2) @(negedge clk_sys);
		check(17'(convHold), 17'h1);
		multiChannel = 1'b0;
		repeat (2) @(negedge clk_sys);
		check(17'({convHold, syncFilterReset}), 17'h0);
		syncIn = 1'b1;
		wr(6'h01, 16'h0020);
		check(17'(contReadActive), 17'h0);
		syncIn = 1'b0;
		wr(6'h02, 16'h0000);
		check(17'({convHold, syncFilterReset, altSyncEn}), 17'h6);
		summarize();
	end
endmodule

`default_nettype wire
